// file: shared/video_output_control_params.svh
// register offsets, field positions, reset values, write masks and sizes
`ifndef VIDEO_OUTPUT_CONTROL_PARAMS_SVH
`define VIDEO_OUTPUT_CONTROL_PARAMS_SVH
`define ADDR_POL        8'h24
`define ADDR_CLK_FMT    8'h25
`define ADDR_TRI_PD     8'h26
`define RST_POL         8'h10
`define RST_CLK_FMT     8'h72
`define RST_TRI_PD      8'h08
`define MASK_POL        8'h11
`define MASK_CLK_FMT    8'hff
`define MASK_TRI_PD     8'hb8
`define BIT_FLD_POL     4
`define BIT_CLK_INV     0
`define BIT_CLK_SEL_HI  7
`define BIT_CLK_SEL_LO  6
`define BIT_DRV_HI      5
`define BIT_DRV_LO      4
`define BIT_MODE_HI     3
`define BIT_MODE_LO     2
`define BIT_PRI_EN      1
`define BIT_SEC_EN      0
`define BIT_TS_VIDEO    7
`define BIT_TS_SPDIF    5
`define BIT_TS_I2S      4
`define BIT_PD_POL      3
`define FIFO_DEPTH      32
`define PIX_WIDTH       24
`define DIV_CNT_WIDTH   4
`endif

// file: shared/video_output_pkg.sv
// types shared by the output stage
package video_output_pkg;
   typedef enum logic [1:0] {
      MODE_444 = 2'b00,
      MODE_422 = 2'b01,
      MODE_DDR = 2'b10,
      MODE_RSV = 2'b11
   } out_mode_t;
   typedef enum logic [1:0] {
      CLK_HALF = 2'b00,
      CLK_ONE  = 2'b01,
      CLK_TWO  = 2'b10,
      CLK_Q90  = 2'b11
   } clk_sel_t;
endpackage : video_output_pkg

// file: shared/pix_stream_if.sv
// valid/ready word stream between the fifo and the output stage
`timescale 1ns/1ps
interface pix_stream_if #(parameter int WIDTH = 25);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : pix_stream_if

// file: hdl/pix_fifo.sv
// flip-flop fifo with a registered full flag; empty is decoded from the registered count
`timescale 1ns/1ps
module pix_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 32
) (
   // clock and reset
   input logic        clk,
   input logic        reset_n,
   // fill side: wr.ready is registered so it can leave the top directly
   pix_stream_if.snk  wr,
   // drain side
   pix_stream_if.src  rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   wire push = wr.valid && wr.ready;
   wire pop  = rd.valid && rd.ready;
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign rd.data    = mem[rd_ptr];
   assign rd.valid   = (count != '0);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         wr.ready <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= AW'(rd_ptr + 1'b1);
         end
         count    <= next_count;
         wr.ready <= (next_count < (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= wr.data;
      end
   end
endmodule : pix_fifo

// file: hdl/video_output_control.sv
// output stage of the video receiver: clock, packing, enables, polarity
`timescale 1ns/1ps
`include "video_output_control_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// R1: field output active low when polarity bit is 0, high when 1; resets 1
// R2: output clock passes unchanged at invert 0, inverted at 1; resets 0
// R3: clock select 00 half, 01 1x (reset), 10 2x, 11 1x shifted 90 degrees
// R4: with pixel repetition the 1x clock is divided down from link clock
// R5: two-bit drive code goes to pads, 00 weakest, 11 strongest, resets 11
// R6: mode 00 4:4:4, 01 4:2:2 plus ddr on blue, 10 ddr 4:4:4 plus ddr blue
// R7: primary output enable resets 1; secondary enable resets 0, modes 1 and 2
// R8: video three-state and serial audio three-state bits, both reset 0
// R9: i2s three-state bit floats i2s data and master clock together; resets 0
// R10: power-down pin is active low when its polarity bit is 0; resets 1
// R11: power-down pin is active high when its polarity bit is 1
// R12: mode 11 is undefined; the stage falls back to plain 4:4:4 packing
module video_output_control (
   // clock and reset
   input  logic        clk,
   input  logic        reset_n,
   // register port
   input  logic        reg_wr,
   input  logic        reg_rd,
   input  logic [7:0]  reg_addr,
   input  logic [7:0]  reg_wdata,
   output logic [7:0]  reg_rdata,
   // pixel source, same clock
   input  logic        pix_valid,
   output logic        pix_ready,
   input  logic [23:0] pix_data,
   input  logic        pix_field,
   // asynchronous pins
   input  logic        pix_rep_pin,
   input  logic        pd_pin,
   // video pins
   output logic        clk_out,
   output logic        field_out,
   output logic [23:0] pri_data,
   output logic        pri_oe,
   output logic [7:0]  sec_data,
   output logic        sec_oe,
   output logic [1:0]  drive_strength,
   // audio pins and power
   output logic        spdif_oe,
   output logic        i2s_oe,
   output logic        mclk_oe,
   output logic        power_down
);
   //////////////////////////////////////////////////////////////////////////
   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      hit = (a == t);
   endfunction : hit

   logic [7:0] pol_reg;
   logic [7:0] fmt_reg;
   logic [7:0] tri_reg;
   wire wr_pol = reg_wr && hit(reg_addr, `ADDR_POL);
   wire wr_fmt = reg_wr && hit(reg_addr, `ADDR_CLK_FMT);
   wire wr_tri = reg_wr && hit(reg_addr, `ADDR_TRI_PD);
   wire [7:0] rd_mux = hit(reg_addr, `ADDR_POL)     ? pol_reg :
                       hit(reg_addr, `ADDR_CLK_FMT) ? fmt_reg :
                       hit(reg_addr, `ADDR_TRI_PD)  ? tri_reg : 8'h00;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pol_reg   <= `RST_POL; // R1 R2
         fmt_reg   <= `RST_CLK_FMT; // R3 R5 R6 R7
         tri_reg   <= `RST_TRI_PD; // R8 R9 R10
         reg_rdata <= 8'h00;
      end else begin
         if (wr_pol) pol_reg <= reg_wdata & `MASK_POL;
         if (wr_fmt) fmt_reg <= reg_wdata & `MASK_CLK_FMT;
         if (wr_tri) tri_reg <= reg_wdata & `MASK_TRI_PD;
         // unmapped offsets read zero
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   wire fld_pol = pol_reg[`BIT_FLD_POL];
   wire clk_inv = pol_reg[`BIT_CLK_INV];
   wire [1:0] sel_raw = fmt_reg[`BIT_CLK_SEL_HI:`BIT_CLK_SEL_LO];
   wire [1:0] mode_raw = fmt_reg[`BIT_MODE_HI:`BIT_MODE_LO];
   wire pri_en = fmt_reg[`BIT_PRI_EN];
   wire sec_en = fmt_reg[`BIT_SEC_EN];
   wire ts_video = tri_reg[`BIT_TS_VIDEO];
   wire ts_spdif = tri_reg[`BIT_TS_SPDIF];
   wire ts_i2s = tri_reg[`BIT_TS_I2S];
   wire pd_pol = tri_reg[`BIT_PD_POL];
   video_output_pkg::clk_sel_t  sel;
   video_output_pkg::out_mode_t mode;
   assign sel  = video_output_pkg::clk_sel_t'(sel_raw);
   assign mode = video_output_pkg::out_mode_t'(mode_raw);

   //////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers for the pins
   logic [1:0] sync1;
   logic [1:0] sync2;
   wire  [1:0] pins = {pd_pin, pix_rep_pin};
   generate
      for (genvar i = 0; i < 2; i++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
            end else begin
               sync1[i] <= pins[i];
               sync2[i] <= sync1[i];
            end
         end
      end
   endgenerate
   wire pix_rep = sync2[0];
   wire pd_s    = sync2[1];

   //////////////////////////////////////////////////////////////////////////
   // clock divider: clk stands for the 2x edge rate of the link clock
   logic [`DIV_CNT_WIDTH-1:0] div_cnt;
   always_ff @(posedge clk) begin
      if (!reset_n) div_cnt <= '0;
      else          div_cnt <= div_cnt + 1'b1;
   end
   // repetition halves every derived rate instead of using the link clock
   wire clk_one  = pix_rep ? div_cnt[2] : div_cnt[1]; // R4
   wire clk_half = pix_rep ? div_cnt[3] : div_cnt[2]; // R4
   wire clk_two  = pix_rep ? div_cnt[1] : div_cnt[0];
   wire clk_q90  = clk_one ^ clk_two;
   wire next_clk = (sel == video_output_pkg::CLK_HALF) ? clk_half :
                   (sel == video_output_pkg::CLK_TWO)  ? clk_two  :
                   (sel == video_output_pkg::CLK_Q90)  ? clk_q90  :
                                                         clk_one; // R3
   // one pixel leaves per 1x period; the source stalls on a full fifo
   wire tick = pix_rep ? (div_cnt[2:0] == 3'h7) : (div_cnt[1:0] == 2'h3);
   wire half = clk_one;

   //////////////////////////////////////////////////////////////////////////
   pix_stream_if #(.WIDTH(`PIX_WIDTH + 1)) fill ();
   pix_stream_if #(.WIDTH(`PIX_WIDTH + 1)) drain ();
   assign fill.valid  = pix_valid;
   assign fill.data   = {pix_field, pix_data};
   assign pix_ready   = fill.ready;
   assign drain.ready = tick;

   pix_fifo #(
      .WIDTH (`PIX_WIDTH + 1),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk     (clk),
      .reset_n (reset_n),
      .wr      (fill),
      .rd      (drain)
   );

   logic [23:0] cur_pix;
   logic        cur_field;
   logic        chroma_b;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cur_pix   <= 24'h000000;
         cur_field <= 1'b0;
         chroma_b  <= 1'b0;
      end else if (drain.valid && drain.ready) begin
         cur_pix   <= drain.data[23:0];
         cur_field <= drain.data[24];
         chroma_b  <= ~chroma_b;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // packing: g carries luma, r/b alternate as chroma per pixel
   wire [7:0] luma   = cur_pix[15:8];
   wire [7:0] chroma = chroma_b ? cur_pix[7:0] : cur_pix[23:16];
   wire is_422 = (mode == video_output_pkg::MODE_422);
   wire is_ddr = (mode == video_output_pkg::MODE_DDR);
   wire dual   = is_422 || is_ddr; // R12
   wire [23:0] next_pri = is_422 ? {8'h00, luma, chroma} :
                          is_ddr ? {12'h000, half ? cur_pix[11:0]
                                                  : cur_pix[23:12]} :
                                   cur_pix; // R6 R12
   wire [7:0] next_sec = dual ? (half ? chroma : luma) : 8'h00; // R6
   wire next_pri_oe = ~ts_video && pri_en; // R7 R8
   wire next_sec_oe = ~ts_video && sec_en && dual; // R7 R8 R12
   wire next_pd = pd_pol ? pd_s : ~pd_s; // R10 R11

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         clk_out        <= 1'b0;
         field_out      <= 1'b0;
         pri_data       <= 24'h000000;
         pri_oe         <= 1'b0;
         sec_data       <= 8'h00;
         sec_oe         <= 1'b0;
         drive_strength <= 2'h3;
         spdif_oe       <= 1'b0;
         i2s_oe         <= 1'b0;
         mclk_oe        <= 1'b0;
         power_down     <= 1'b0;
      end else begin
         clk_out        <= next_clk ^ clk_inv; // R2
         field_out      <= fld_pol ? cur_field : ~cur_field; // R1
         pri_data       <= next_pri;
         pri_oe         <= next_pri_oe;
         sec_data       <= next_sec;
         sec_oe         <= next_sec_oe;
         drive_strength <= fmt_reg[`BIT_DRV_HI:`BIT_DRV_LO]; // R5
         spdif_oe       <= ~ts_spdif; // R8
         i2s_oe         <= ~ts_i2s; // R9
         mclk_oe        <= ~ts_i2s; // R9
         power_down     <= next_pd;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_field_polarity: assert property ( // R1
      ##1 field_out == ($past(fld_pol) ~^ $past(cur_field)))
      else $error("field output polarity wrong");
   chk_clock_invert: assert property ( // R2
      (clk_inv && $stable(sel)) ##1 clk_inv |-> clk_out == ~$past(next_clk))
      else $error("inverted clock does not follow selection");
   chk_twox_toggle: assert property ( // R3
      (sel == video_output_pkg::CLK_TWO && !pix_rep
       && $stable(clk_inv)) [*3] |->
      clk_out != $past(clk_out))
      else $error("2x clock does not toggle every edge");
   chk_rep_divide: assert property ( // R4
      (pix_rep && sel == video_output_pkg::CLK_ONE && !clk_inv) [*3] |->
      clk_out == $past(div_cnt[2]))
      else $error("1x clock not divided under repetition");
   chk_drive_code: assert property ( // R5
      wr_fmt |-> ##2 drive_strength == $past(reg_wdata[5:4], 2))
      else $error("drive code not passed to pads");
   chk_packing_mode: assert property ( // R6
      (mode == video_output_pkg::MODE_444) |-> ##1
      (pri_data == $past(cur_pix) && sec_data == 8'h00))
      else $error("normal packing altered");
   chk_secondary_enable: assert property ( // R7
      sec_oe |-> $past(sec_en) && $past(dual) && !$past(ts_video))
      else $error("secondary output enabled without cause");
   chk_video_float: assert property ( // R8
      ts_video [*2] |-> !pri_oe && !sec_oe)
      else $error("video outputs driven while three-stated");
   chk_i2s_pair: assert property ( // R9
      (i2s_oe == mclk_oe) and (ts_i2s [*2] |-> !i2s_oe))
      else $error("i2s and master clock enables split");
   chk_powerdown_pol: assert property ( // R10
      ##1 power_down == ($past(pd_pol) ~^ $past(pd_s)))
      else $error("power-down pin polarity wrong");
   chk_reserved_mode: assert property ( // R12
      (mode == video_output_pkg::MODE_RSV) [*2] |->
      !sec_oe && pri_data == $past(cur_pix))
      else $error("reserved mode not treated as 4:4:4");
   chk_fifo_stall: assert property (
      (pix_valid && !pix_ready) [*2] |-> $stable(u_fifo.count))
      else $error("fifo grows while stalled");

   cov_mode_422: cover property (is_422 && sec_oe ##1 drain.valid && tick);
   cov_mode_ddr: cover property (is_ddr && pri_oe && sec_oe);
   cov_fifo_full: cover property (pix_valid && !pix_ready);
   cov_rep_quarter: cover property (
      pix_rep && sel == video_output_pkg::CLK_Q90);
endmodule : video_output_control

// file: verification/display_sink.sv
// downstream display model: latches the pixel bus on output clock rises
`timescale 1ns/1ps
module display_sink (
   // clock and reset
   input  logic        clk,
   input  logic        reset_n,
   // pixel bus from the output stage
   input  logic        clk_out,
   input  logic        pri_oe,
   input  logic [23:0] pri_data,
   input  logic        field_out,
   // what the display last took in
   output logic [23:0] last_pix,
   output logic        last_field
);
   logic prev_clk;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prev_clk <= 1'b0;
         last_pix <= 24'h0;
         last_field <= 1'b0;
      end else begin
         prev_clk <= clk_out;
         // a floating bus carries nothing, so only driven words are taken
         if (clk_out && !prev_clk && pri_oe) begin
            last_pix <= pri_data;
            last_field <= field_out;
         end
      end
   end
endmodule : display_sink

// file: verification/tb.sv
// self-checking bench for the video output stage
`timescale 1ns/1ps
`include "video_output_control_params.svh"
module tb;
   logic        clk, reset_n, reg_wr, reg_rd, pix_valid, pix_ready;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, sec_data, rb;
   logic [23:0] pix_data, pri_data, last_pix, nxt;
   logic        pix_field, pix_rep_pin, pd_pin, clk_out, field_out;
   logic        pri_oe, sec_oe, spdif_oe, i2s_oe, mclk_oe, power_down;
   logic        last_field;
   logic        taken;
   logic [1:0]  drive_strength;
   logic [7:0]  p0, p1;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n;
   video_output_control dut (.clk(clk), .reset_n(reset_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
      .pix_ready(pix_ready), .pix_data(pix_data), .pix_field(pix_field),
      .pix_rep_pin(pix_rep_pin), .pd_pin(pd_pin), .clk_out(clk_out),
      .field_out(field_out), .pri_data(pri_data), .pri_oe(pri_oe),
      .sec_data(sec_data), .sec_oe(sec_oe), .drive_strength(drive_strength),
      .spdif_oe(spdif_oe), .i2s_oe(i2s_oe), .mclk_oe(mclk_oe),
      .power_down(power_down));
   display_sink sink (.clk(clk), .reset_n(reset_n), .clk_out(clk_out),
      .pri_oe(pri_oe), .pri_data(pri_data), .field_out(field_out),
      .last_pix(last_pix), .last_field(last_field));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   //////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic chk1(input logic seen, input logic exp);
      check({23'h0, seen}, {23'h0, exp});
   endtask : chk1
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      check({16'h0, reg_rdata}, {16'h0, exp});
   endtask : rd
   // second period is used: the first may straddle a rate change
   task automatic period(output int k);
      repeat (2) begin
         while (clk_out !== 1'b0) @(negedge clk);
         while (clk_out !== 1'b1) @(negedge clk);
         k = 0;
         while (clk_out !== 1'b0) begin @(negedge clk); k++; end
         while (clk_out !== 1'b1) begin @(negedge clk); k++; end
      end
   endtask : period
   task automatic grab(output logic [7:0] p);
      while (cyc % 8 != 0) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         p[i] = clk_out;
         @(negedge clk);
      end
   endtask : grab
   task automatic show(input logic [23:0] p, input logic f,
                       input logic [23:0] e);
      int k;
      @(negedge clk);
      pix_valid = 1'b1;
      pix_data = p;
      pix_field = f;
      @(negedge clk);
      pix_valid = 1'b0;
      k = 0;
      while (pri_data !== e && k < 100) begin @(negedge clk); k++; end
      check(pri_data, e);
   endtask : show
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      {reset_n, reg_wr, reg_rd, pix_valid, pix_field} = 5'h0;
      {reg_addr, reg_wdata, pix_data} = 40'h0;
      {pix_rep_pin, pd_pin} = 2'h0;
      repeat (12) @(negedge clk);
      check({22'h0, drive_strength}, 24'h3);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      check({19'h0, pri_oe, sec_oe, spdif_oe, i2s_oe, mclk_oe},
            24'h17);
      rd(`ADDR_POL, 8'h10);
      rd(`ADDR_CLK_FMT, 8'h72);
      rd(`ADDR_TRI_PD, 8'h08);
      rd(8'h27, 8'h00);
      wr(`ADDR_POL, 8'hff);
      rd(`ADDR_POL, 8'h11);
      wr(`ADDR_TRI_PD, 8'hff);
      rd(`ADDR_TRI_PD, 8'hb8);
      wr(`ADDR_POL, 8'h10);
      wr(`ADDR_TRI_PD, 8'h08);
      for (int d = 0; d < 4; d++) begin
         wr(`ADDR_CLK_FMT, {2'b01, d[1:0], 4'h2});
         check({22'h0, drive_strength}, 24'(d));
      end
      // expected periods in clk cycles: half 8, 1x 4, 2x 2, 90 degree 4; twice these with repetition
      for (int r = 0; r < 2; r++) begin
         pix_rep_pin = r[0];
         for (int s = 0; s < 4; s++) begin
            wr(`ADDR_CLK_FMT, {s[1:0], 6'h32});
            period(n);
            check(24'(n), 24'((s == 0 ? 8 : s == 2 ? 2 : 4) << r));
         end
      end
      pix_rep_pin = 1'b0;
      wr(`ADDR_CLK_FMT, 8'h72);
      repeat (8) @(negedge clk);
      grab(p0);
      wr(`ADDR_POL, 8'h11);
      grab(p1);
      check({16'h0, p1}, {16'h0, ~p0});
      wr(`ADDR_POL, 8'h10);
      show(24'ha5c33c, 1'b1, 24'ha5c33c);
      chk1(field_out, 1'b1);
      repeat (16) @(negedge clk);
      check(last_pix, 24'ha5c33c);
      wr(`ADDR_POL, 8'h00);
      chk1(field_out, 1'b0);
      wr(`ADDR_CLK_FMT, 8'h7f);
      chk1(sec_oe, 1'b0);
      show(24'h17e281, 1'b0, 24'h17e281);
      for (int m = 0; m < 4; m++) begin
         wr(`ADDR_CLK_FMT, {4'h7, m[1:0], 2'h3});
         chk1(sec_oe, m == 1 || m == 2);
         chk1(pri_oe, 1'b1);
      end
      wr(`ADDR_CLK_FMT, 8'h71);
      chk1(pri_oe, 1'b0);
      // r equals b, so either chroma phase carries the same byte
      wr(`ADDR_CLK_FMT, 8'h77);
      show(24'h5a3c5a, 1'b0, 24'h003c5a);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         check({16'h0, sec_data}, {16'h0, clk_out ? 8'h5a : 8'h3c});
      end
      wr(`ADDR_CLK_FMT, 8'h72);
      foreach (p0[i]) p0[i] = 1'b0;
      wr(`ADDR_TRI_PD, 8'h88);
      check({20'h0, pri_oe, spdif_oe, i2s_oe, mclk_oe}, 24'h7);
      wr(`ADDR_TRI_PD, 8'h28);
      check({20'h0, pri_oe, spdif_oe, i2s_oe, mclk_oe}, 24'hb);
      wr(`ADDR_TRI_PD, 8'h18);
      check({20'h0, pri_oe, spdif_oe, i2s_oe, mclk_oe}, 24'hc);
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_TRI_PD, {4'h1, i[1], 3'h0});
         pd_pin = i[0];
         repeat (5) @(negedge clk);
         chk1(power_down, i[1] ? i[0] : !i[0]);
      end
      wr(`ADDR_TRI_PD, 8'h08);
      // fill faster than the 1x drain and keep offering while refused;
      // ready is registered, so its value at the falling edge decides
      nxt = 24'h100000;
      rb = 8'h00;
      @(negedge clk);
      pix_valid = 1'b1;
      pix_data = nxt;
      for (int c = 0; c < 60; c++) begin
         taken = (pix_ready === 1'b1);
         if (!taken) rb = rb + 8'h01;
         @(negedge clk);
         if (taken) nxt = nxt + 24'h1;
         pix_data = nxt;
      end
      pix_valid = 1'b0;
      chk1(rb > 8'h02, 1'b1);
      n = 0;
      while (pri_data !== nxt - 24'h1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check(pri_data, nxt - 24'h1);
      chk1(pix_ready, 1'b1);
      complete_run();
   end
endmodule : tb
